// file: gdid_defines.svh
/*
 * Timing and width constants for the gate drive input decoder.
 * Assumes a 25 MHz system clock; included by its bare name.
 */
`ifndef GDID_DEFINES_SVH
`define GDID_DEFINES_SVH

// System clock period in nanoseconds.
`define GDID_CLK_NS 40
// Least dead time kept in six-input mode, in nanoseconds.
`define GDID_MIN_DT_NS 200
// Least dead time in whole clock cycles, rounded up.
`define GDID_MIN_DT_CYC ((`GDID_MIN_DT_NS + `GDID_CLK_NS - 1) / `GDID_CLK_NS)
// Half period of the alternating brake pattern, in nanoseconds.
`define GDID_BRK_ALT_NS 10000
// Alternating brake half period in clock cycles, rounded down.
`define GDID_BRK_ALT_CYC (`GDID_BRK_ALT_NS / `GDID_CLK_NS)
// Width of the dead time settings.
`define GDID_DT_W 8
// Width of the brake alternation counter.
`define GDID_ALT_W 16

`endif

// file: gdid_pkg.sv
/*
 * Types shared by the gate drive input decoder and its dead time units.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gdid_pkg;

	// Drive mode select codes.
	typedef enum logic [2:0] {
		GDID_SIX = 3'h0,
		GDID_THREE = 3'h1,
		GDID_ONE_PAT = 3'h2,
		GDID_ONE_HALL = 3'h3,
		GDID_ONE_HALL_ALT = 3'h4
	} gdid_mode_t;

	// Brake reactions.
	typedef enum logic [1:0] {
		GDID_BRK_LOW = 2'h0,
		GDID_BRK_HIGH = 2'h1,
		GDID_BRK_ALT = 2'h2,
		GDID_BRK_OFF = 2'h3
	} gdid_brake_t;

	// Dead time unit states.
	typedef enum logic [1:0] {
		GDID_DT_OFF = 2'h0,
		GDID_DT_HIGH = 2'h1,
		GDID_DT_LOW = 2'h2
	} gdid_dt_state_t;

endpackage

// file: gdid_phase_if.sv
/*
 * Per-phase link between the input decoder and one dead time unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface gdid_phase_if #(
	parameter int DT_W = 8
) ();
	// Requested gate states, never both high.
	logic req_hi;
	logic req_lo;
	// Off time before the high gate and before the low gate may turn on.
	logic [DT_W-1:0] dt_hi;
	logic [DT_W-1:0] dt_lo;
	// Gate commands as driven.
	logic gate_hi;
	logic gate_lo;

	modport ctrl (output req_hi, output req_lo, output dt_hi, output dt_lo,
		input gate_hi, input gate_lo);
	modport unit (input req_hi, input req_lo, input dt_hi, input dt_lo,
		output gate_hi, output gate_lo);
endinterface

// file: gdid_dead_time.sv
/*
 * Dead time unit for one half bridge: turns a gate on only after the
 * opposing gate has been off for the requested number of cycles.
 * Assumes the requests come from logic on the same clock.
 */
`timescale 1ns/100ps
module gdid_dead_time
	import gdid_pkg::*;
#(
	parameter int DT_W = 8
)
(
	input wire logic mclk,
	input wire logic rst,
	gdid_phase_if.unit ph
);

	// Whole state: gate state, off-cycle count, checking run length.
	typedef struct packed {
		gdid_dt_state_t state;
		logic [DT_W-1:0] cnt;
		logic [DT_W-1:0] chk_off;
	} gdid_dt_reg_t;

	gdid_dt_reg_t st_ff;
	gdid_dt_reg_t nxt_st;

	// Next state: a gate goes off at once and on only after the gap.
	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff.state)
			GDID_DT_OFF:
			begin
				// Count off cycles, saturating.
				if (st_ff.cnt != '1)
				begin
					nxt_st.cnt = st_ff.cnt + 1'b1;
				end
				if (ph.req_hi && !ph.req_lo && st_ff.cnt >= ph.dt_hi)
				begin
					nxt_st.state = GDID_DT_HIGH;
				end
				else if (ph.req_lo && !ph.req_hi && st_ff.cnt >= ph.dt_lo)
				begin
					nxt_st.state = GDID_DT_LOW;
				end
			end
			GDID_DT_HIGH:
			begin
				// Dropping a request turns the gate off next cycle.
				if (!ph.req_hi || ph.req_lo)
				begin
					nxt_st.state = GDID_DT_OFF;
					nxt_st.cnt = DT_W'(1);
				end
			end
			GDID_DT_LOW:
			begin
				if (!ph.req_lo || ph.req_hi)
				begin
					nxt_st.state = GDID_DT_OFF;
					nxt_st.cnt = DT_W'(1);
				end
			end
			default:
			begin
				// Unused code falls back to both gates off.
				nxt_st.state = GDID_DT_OFF;
				nxt_st.cnt = DT_W'(1);
			end
		endcase
		// Independent run of cycles with both gates off.
		if (ph.gate_hi || ph.gate_lo)
		begin
			nxt_st.chk_off = '0;
		end
		else if (st_ff.chk_off != '1)
		begin
			nxt_st.chk_off = st_ff.chk_off + 1'b1;
		end
	end

	// State register; reset leaves both gates off.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_ff <= '{state: GDID_DT_OFF, cnt: DT_W'(1), chk_off: '0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Gate commands decode the registered state.
	assign ph.gate_hi = (st_ff.state == GDID_DT_HIGH);
	assign ph.gate_lo = (st_ff.state == GDID_DT_LOW);

	// High gate turns on only after the low gate was off long enough.
	dt_gap_high_a: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(ph.gate_hi) |-> (st_ff.chk_off >= $past(ph.dt_hi)) && (st_ff.chk_off != '0))
		else $error("High gate turned on before its dead time elapsed.");

	// Low gate turns on only after the high gate was off long enough.
	dt_gap_low_a: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(ph.gate_lo) |-> (st_ff.chk_off >= $past(ph.dt_lo)) && (st_ff.chk_off != '0))
		else $error("Low gate turned on before its dead time elapsed.");

endmodule

// file: gdid_decoder.sv
/*
 * Gate drive input decoder: turns three-phase PWM inputs into high and
 * low gate commands, with brake override and dead time insertion.
 * Assumes all inputs are synchronous to mclk and that the dead time
 * settings and modes are held steady by the surrounding control logic.
 */
`timescale 1ns/100ps
`include "gdid_defines.svh"

// Function
// - mode field picks one of five behaviours; codes 2 to 4 here turn all gates off unless a brake acts, and raise mode_unsupported
// - mode zero gives six independent inputs
// - six-input mode still keeps a least gap
// - six-input: single high drives gate, else off
// - active brake overrides inputs in every mode
// - brake: lows, highs, alternating, or all off
// - mode one gives three high-side inputs
// - three-input: low side is complement plus gap
// - three-input: low input high turns both off
// - rising and falling gaps set separately; only three-input mode uses them, other modes use the least gap for both
module gdid_decoder
	import gdid_pkg::*;
#(
	parameter int DT_W = `GDID_DT_W,
	parameter int MIN_DT_CYC = `GDID_MIN_DT_CYC,
	parameter int BRK_ALT_CYC = `GDID_BRK_ALT_CYC,
	parameter int ALT_W = `GDID_ALT_W
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] drive_mode_sel,
	input wire logic [1:0] brake_cfg,
	input wire logic [DT_W-1:0] dead_time_rising,
	input wire logic [DT_W-1:0] dead_time_falling,
	input wire logic [2:0] high_side_input,
	input wire logic [2:0] low_side_input,
	input wire logic brake_request_n,
	output logic [2:0] high_gate_out,
	output logic [2:0] low_gate_out,
	output logic mode_unsupported
);

	// Small dead time used by the checks below.
	// A gap below this shows its gate inside an eight-cycle window.
	localparam logic [DT_W-1:0] CHK_SMALL_DT = DT_W'(7);

	// Whole state of the decoder.
	typedef struct packed {
		// Alternating brake is on its high-side half.
		logic brk_hi;
		// Cycles spent in the current alternating half.
		logic [ALT_W-1:0] alt_cnt;
		// Selected mode is not handled by this block.
		logic unsup;
	} gdid_dec_reg_t;

	gdid_dec_reg_t st_ff;
	gdid_dec_reg_t nxt_st;

	// Decoded mode and brake choice.
	gdid_mode_t mode;
	gdid_brake_t brake;

	// Gate requests per phase before dead time.
	logic [2:0] rq_hi;
	logic [2:0] rq_lo;

	// Dead times handed to every phase.
	logic [DT_W-1:0] dead_time_rising_sel;
	logic [DT_W-1:0] dead_time_falling_sel;

	// Maps one phase's inputs to requested gates, high first.
	function automatic logic [1:0] gdid_decode_phase(
		input gdid_mode_t m,
		input logic hi,
		input logic lo
	);
		logic [1:0] res;
		res = 2'h0;
		unique case (m)
			GDID_SIX:
			begin
				res = {hi & ~lo, lo & ~hi};
			end
			GDID_THREE:
			begin
				if (lo)
				begin
					res = 2'h0;
				end
				else
				begin
					res = {hi, ~hi};
				end
			end
			GDID_ONE_PAT, GDID_ONE_HALL, GDID_ONE_HALL_ALT:
			begin
				// Single-input modes are left with both gates off.
				res = 2'h0;
			end
			default:
			begin
				// Illegal codes leave both gates off.
				res = 2'h0;
			end
		endcase
		return res;
	endfunction

	// Mode, brake pattern and dead time selection.
	always_comb
	begin
		nxt_st = st_ff;
		mode = gdid_mode_t'(drive_mode_sel);
		brake = gdid_brake_t'(brake_cfg);
		nxt_st.unsup = (mode != GDID_SIX) && (mode != GDID_THREE);

		// Alternation timer runs only while the alternating brake acts.
		if (!brake_request_n && brake == GDID_BRK_ALT)
		begin
			if (st_ff.alt_cnt >= ALT_W'(BRK_ALT_CYC - 1))
			begin
				nxt_st.alt_cnt = '0;
				nxt_st.brk_hi = ~st_ff.brk_hi;
			end
			else
			begin
				nxt_st.alt_cnt = st_ff.alt_cnt + 1'b1;
			end
		end
		else
		begin
			// Each brake event starts on the low-side half.
			nxt_st.alt_cnt = '0;
			nxt_st.brk_hi = 1'b0;
		end

		// Per-phase decode of the PWM inputs.
		for (int i = 0; i < 3; i++)
		begin
			{rq_hi[i], rq_lo[i]} = gdid_decode_phase(mode, high_side_input[i],
				low_side_input[i]);
		end

		if (!brake_request_n)
		begin
			unique case (brake)
				GDID_BRK_LOW:
				begin
					rq_hi = 3'h0;
					rq_lo = 3'h7;
				end
				GDID_BRK_HIGH:
				begin
					rq_hi = 3'h7;
					rq_lo = 3'h0;
				end
				GDID_BRK_ALT:
				begin
					rq_hi = {3{st_ff.brk_hi}};
					rq_lo = {3{~st_ff.brk_hi}};
				end
				GDID_BRK_OFF:
				begin
					rq_hi = 3'h0;
					rq_lo = 3'h0;
				end
			endcase
		end

		if (mode == GDID_THREE)
		begin
			dead_time_rising_sel = dead_time_rising;
			dead_time_falling_sel = dead_time_falling;
		end
		else
		begin
			dead_time_rising_sel = DT_W'(MIN_DT_CYC);
			dead_time_falling_sel = DT_W'(MIN_DT_CYC);
		end
	end

	// State register.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_ff <= '{brk_hi: 1'b0, alt_cnt: '0, unsup: 1'b0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign mode_unsupported = st_ff.unsup;

	// One link and one dead time unit per phase.
	gdid_phase_if #(.DT_W(DT_W)) ph_if [3] ();

	// Rising phase node means the high gate turns on; falling, the low gate.
	for (genvar g = 0; g < 3; g++)
	begin : g_phase
		assign ph_if[g].req_hi = rq_hi[g];
		assign ph_if[g].req_lo = rq_lo[g];
		assign ph_if[g].dt_hi = dead_time_rising_sel;
		assign ph_if[g].dt_lo = dead_time_falling_sel;
		assign high_gate_out[g] = ph_if[g].gate_hi;
		assign low_gate_out[g] = ph_if[g].gate_lo;

		gdid_dead_time #(
			.DT_W(DT_W)
		) u_dt (
			.mclk(mclk),
			.rst(rst),
			.ph(ph_if[g])
		);
	end

	// The checks below all use the system clock and reset.
	default clocking gdid_cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Never both gates of a phase on together.
	no_shoot_thru_a: assert property (
		(high_gate_out & low_gate_out) == 3'h0)
		else $error("Both gates of a phase are on.");

	// Equal inputs in six-input mode turn every gate off.
	six_equal_off_a: assert property (
		(mode == GDID_SIX && brake_request_n && high_side_input == low_side_input)
		|=> (high_gate_out == 3'h0) && (low_gate_out == 3'h0))
		else $error("Six-input equal inputs left a gate on.");

	// A lone high input on phase 0 reaches its gate within eight cycles.
	six_high_on_a: assert property (
		(mode == GDID_SIX && brake_request_n && high_side_input[0]
		&& !low_side_input[0])[*8]
		|-> high_gate_out[0] && !low_gate_out[0])
		else $error("Six-input high request not honoured.");

	// Low input high in three-input mode floats the phase.
	three_lo_kill_a: assert property (
		(mode == GDID_THREE && brake_request_n && low_side_input[0])
		|=> !high_gate_out[0] && !low_gate_out[0])
		else $error("Three-input low input did not float the phase.");

	// Low input inactive and high input low drives the low gates.
	three_compl_a: assert property (
		(mode == GDID_THREE && brake_request_n && low_side_input == 3'h0
		&& high_side_input == 3'h0 && dead_time_falling < CHK_SMALL_DT)[*8]
		|-> low_gate_out == 3'h7)
		else $error("Three-input low side not generated.");

	// High inputs drive the high gates after the rising gap.
	three_rise_a: assert property (
		(mode == GDID_THREE && brake_request_n && low_side_input == 3'h0
		&& high_side_input == 3'h7 && dead_time_rising < CHK_SMALL_DT)[*8]
		|-> high_gate_out == 3'h7)
		else $error("Three-input high side not driven after rising gap.");

	// Off brake floats every phase at once whatever the inputs.
	brake_off_a: assert property (
		(!brake_request_n && brake == GDID_BRK_OFF)
		|=> (high_gate_out == 3'h0) && (low_gate_out == 3'h0))
		else $error("Off brake left a gate on.");

	// Low brake drops high gates and then turns on all lows.
	brake_low_a: assert property (
		(!brake_request_n && brake == GDID_BRK_LOW && mode == GDID_SIX)[*8]
		|-> (low_gate_out == 3'h7) && (high_gate_out == 3'h0))
		else $error("Low brake pattern not applied.");

	// Alternating brake swaps halves only after a full half period.
	brake_alt_a: assert property (
		$changed(st_ff.brk_hi) && !$past(brake_request_n) && $past(brake) == GDID_BRK_ALT
		|-> $past(st_ff.alt_cnt) == ALT_W'(BRK_ALT_CYC - 1))
		else $error("Alternating brake half period wrong.");

	// Unhandled modes with no brake request keep every gate off and raise the status.
	mode_unsup_a: assert property (
		(brake_request_n && mode != GDID_SIX && mode != GDID_THREE)
		|=> (high_gate_out == 3'h0) && (low_gate_out == 3'h0) && mode_unsupported)
		else $error("Unhandled mode drove a gate.");

endmodule

// file: gdid_pwm_src.sv
/*
 * Controller model: registers PWM commands onto the decoder inputs.
 * Assumes the bench sets its commands on the same clock.
 */
`timescale 1ns/100ps
module gdid_pwm_src (
	input wire logic mclk,
	input wire logic pair_en,
	input wire logic [2:0] hi_cmd,
	input wire logic [2:0] lo_cmd,
	input wire logic brk_cmd_n,
	output logic [2:0] high_side_input = 3'h0,
	output logic [2:0] low_side_input = 3'h0,
	output logic brake_request_n = 1'b1
);
	// Outputs change just after each edge, like a real timer unit.
	always @(posedge mclk)
	begin
		brake_request_n <= brk_cmd_n;
		if (pair_en)
		begin
			// Each side waits one cycle after the other side has fallen.
			high_side_input <= hi_cmd & ~low_side_input;
			low_side_input <= ~hi_cmd & ~high_side_input;
		end
		else
		begin
			// Raw commands; the bench keeps unused bits at zero.
			high_side_input <= hi_cmd;
			low_side_input <= lo_cmd;
		end
	end
endmodule

// file: gdid_decoder_tb_top.sv
/*
 * Self-checking bench for the gate drive input decoder.
 * Assumes the controller model drives all PWM and brake inputs.
 */
`timescale 1ns/100ps
module gdid_decoder_tb_top;
	import gdid_pkg::*;
	// Short counts keep the run brief.
	localparam int MIN_DT = 3;
	localparam int ALT = 8;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] drive_mode_sel = 3'h0;
	logic [1:0] brake_cfg = 2'h0;
	logic [7:0] dead_time_rising = 8'h06;
	logic [7:0] dead_time_falling = 8'h02;
	logic pair_en = 1'b0;
	logic [2:0] hi_cmd = 3'h0;
	logic [2:0] lo_cmd = 3'h0;
	logic brk_cmd_n = 1'b1;
	logic [2:0] high_side_input;
	logic [2:0] low_side_input;
	logic brake_request_n;
	logic [2:0] high_gate_out;
	logic [2:0] low_gate_out;
	logic mode_unsupported;
	int fail_count = 0;
	int samples_checked = 0;

	// Clock of 40 ns period.
	always #20 mclk = ~mclk;

	gdid_pwm_src u_src (.mclk(mclk), .pair_en(pair_en), .hi_cmd(hi_cmd), .lo_cmd(lo_cmd),
		.brk_cmd_n(brk_cmd_n), .high_side_input(high_side_input),
		.low_side_input(low_side_input), .brake_request_n(brake_request_n));

	gdid_decoder #(.MIN_DT_CYC(MIN_DT), .BRK_ALT_CYC(ALT)) u_dut (.mclk(mclk), .rst(rst),
		.drive_mode_sel(drive_mode_sel), .brake_cfg(brake_cfg),
		.dead_time_rising(dead_time_rising), .dead_time_falling(dead_time_falling),
		.high_side_input(high_side_input), .low_side_input(low_side_input),
		.brake_request_n(brake_request_n), .high_gate_out(high_gate_out),
		.low_gate_out(low_gate_out), .mode_unsupported(mode_unsupported));

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares both gate vectors of all phases.
	task automatic gates(input logic [2:0] eh, input logic [2:0] el);
		check(32'({high_gate_out, low_gate_out}), 32'({eh, el}));
	endtask

	// Lets n edges pass, then samples where outputs have settled.
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Sets the mode, the brake and the controller commands at an edge.
	task automatic drive(input logic [2:0] md, input logic pe, input logic [2:0] h,
		input logic [2:0] l, input logic bn, input logic [1:0] cfg);
		@(posedge mclk);
		drive_mode_sel <= md;
		pair_en <= pe;
		hi_cmd <= h;
		lo_cmd <= l;
		brk_cmd_n <= bn;
		brake_cfg <= cfg;
	endtask

	// Waits until the opposing gates are off, then counts cycles to target on.
	task automatic gap(input logic to_hi, input int exp);
		int n;
		n = 0;
		// Step off the edge so the gates are read once they have settled.
		#1;
		while (((to_hi ? low_gate_out : high_gate_out) !== 3'h0) && n < 600)
		begin
			cyc(1);
			n++;
		end
		n = 0;
		while (((to_hi ? high_gate_out : low_gate_out) !== 3'h7) && n < 600)
		begin
			cyc(1);
			n++;
		end
		check(32'(n), 32'(exp));
	endtask

	// Main sequence of scenarios.
	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		cyc(1);
		gates(3'h0, 3'h0);
		check(32'(mode_unsupported), 32'h0);
		// Six-input mode with a complementary pair from the controller.
		drive(3'h0, 1'b1, 3'h0, 3'h0, 1'b1, 2'h0);
		cyc(MIN_DT + 4);
		gates(3'h0, 3'h7);
		drive(3'h0, 1'b1, 3'h7, 3'h0, 1'b1, 2'h0);
		gap(1'b1, MIN_DT);
		drive(3'h0, 1'b1, 3'h0, 3'h0, 1'b1, 2'h0);
		gap(1'b0, MIN_DT);
		// Per-phase table: high only, low only, both, neither.
		drive(3'h0, 1'b0, 3'h5, 3'h6, 1'b1, 2'h0);
		cyc(MIN_DT + 4);
		gates(3'h1, 3'h2);
		drive(3'h0, 1'b0, 3'h0, 3'h0, 1'b1, 2'h0);
		cyc(3);
		gates(3'h0, 3'h0);
		// Single-input and illegal codes turn every gate off.
		for (int m = 2; m < 8; m++)
		begin
			drive(3'(m), 1'b0, 3'h7, 3'h0, 1'b1, 2'h0);
			cyc(MIN_DT + 4);
			gates(3'h0, 3'h0);
			check(32'(mode_unsupported), 32'h1);
		end
		// Three-input mode with separate rising and falling gaps.
		drive(3'h1, 1'b0, 3'h0, 3'h0, 1'b1, 2'h0);
		cyc(12);
		gates(3'h0, 3'h7);
		check(32'(mode_unsupported), 32'h0);
		drive(3'h1, 1'b0, 3'h7, 3'h0, 1'b1, 2'h0);
		gap(1'b1, 6);
		drive(3'h1, 1'b0, 3'h0, 3'h0, 1'b1, 2'h0);
		gap(1'b0, 2);
		drive(3'h1, 1'b0, 3'h7, 3'h0, 1'b1, 2'h0);
		dead_time_falling <= 8'h00;
		cyc(12);
		drive(3'h1, 1'b0, 3'h0, 3'h0, 1'b1, 2'h0);
		gap(1'b0, 1);
		drive(3'h1, 1'b0, 3'h5, 3'h7, 1'b1, 2'h0);
		cyc(3);
		gates(3'h0, 3'h0);
		// Brake patterns override the six-input decode; the off brake also overrides the three-input decode.
		drive(3'h0, 1'b0, 3'h7, 3'h0, 1'b1, 2'h0);
		cyc(MIN_DT + 4);
		drive(3'h0, 1'b0, 3'h7, 3'h0, 1'b0, 2'h0);
		gap(1'b0, MIN_DT);
		// Hold the low brake long enough for its pattern to be watched.
		cyc(4);
		gates(3'h0, 3'h7);
		drive(3'h0, 1'b0, 3'h7, 3'h0, 1'b1, 2'h0);
		gap(1'b1, MIN_DT);
		drive(3'h0, 1'b0, 3'h0, 3'h7, 1'b1, 2'h0);
		gap(1'b0, MIN_DT);
		drive(3'h0, 1'b0, 3'h0, 3'h7, 1'b0, 2'h1);
		gap(1'b1, MIN_DT);
		drive(3'h0, 1'b0, 3'h7, 3'h0, 1'b1, 2'h1);
		cyc(4);
		drive(3'h0, 1'b0, 3'h7, 3'h0, 1'b0, 2'h2);
		gap(1'b0, MIN_DT);
		gap(1'b1, MIN_DT);
		gap(1'b0, MIN_DT);
		drive(3'h1, 1'b0, 3'h7, 3'h0, 1'b0, 2'h3);
		cyc(3);
		gates(3'h0, 3'h0);
		test_done();
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		#(40 * 6000);
		fail_count++;
		$display("Error at %0t: watchdog expired %h %h", $time, 1'b1, 1'b0);
		test_done();
	end
endmodule
